// >>> design/ilvu_map.vh
`ifndef ILVU_MAP_VH
`define ILVU_MAP_VH
// register offsets of the level groups and the status/mask pair
`define ILVU_OFF_LVL0 8'h79
`define ILVU_OFF_LVL1 8'h7a
`define ILVU_OFF_LVL2 8'h7b
`define ILVU_OFF_LVL3 8'h7c
`define ILVU_OFF_LVL4 8'h7d
`define ILVU_OFF_LVL5 8'h7e
`define ILVU_OFF_STAT0 8'h60
`define ILVU_OFF_STAT1 8'h61
`define ILVU_OFF_STAT2 8'h62
`define ILVU_OFF_MASK0 8'h64
`define ILVU_OFF_MASK1 8'h65
`define ILVU_OFF_MASK2 8'h66
`define ILVU_OFF_CTRL 8'h68
// reset values
`define ILVU_LVL_RST 8'hff
`define ILVU_ZERO8 8'h00
`define ILVU_ZERO24 24'h000000
`define ILVU_CTRL_RST 8'h03
// read value of an unimplemented location; arbitrary pattern
`define ILVU_UNDEF 8'ha5
// vector table: request 0 at the top pair, two bytes per step down
`define ILVU_VEC_TOP 16'hfffa
`define ILVU_LVL_LOW 2'h3
`define ILVU_NREQ 24
`endif

// >>> design/ilvu_prio_cell.v
`timescale 1ns/1ns
// one comparison stage: keeps the more urgent of two candidates,
// lower request number wins a tie
module ilvu_prio_cell (
  input wire a_vld_i,
  input wire [1:0] a_lvl_i,
  input wire [4:0] a_num_i,
  input wire b_vld_i,
  input wire [1:0] b_lvl_i,
  input wire [4:0] b_num_i,
  output wire o_vld_o,
  output wire [1:0] o_lvl_o,
  output wire [4:0] o_num_o
);
  wire pick_b;
  // b wins when a is empty or b is strictly more urgent; a always holds lower numbers
  assign pick_b = b_vld_i && (!a_vld_i || (b_lvl_i < a_lvl_i));
  assign o_vld_o = a_vld_i | b_vld_i;
  assign o_lvl_o = pick_b ? b_lvl_i : a_lvl_i;
  assign o_num_o = pick_b ? b_num_i : a_num_i;
endmodule // ilvu_prio_cell

// >>> design/ilvu_top.v
`timescale 1ns/1ns
`include "ilvu_map.vh"
// Notes on behaviour
// - requests 0..23, vector pair from fffa downward
// - equal level ties go to lowest number
// - each request has a two-bit level field
// - level registers read/write, reset all ones
// - ext ch2/6 share 2, ch3/7 share 3
// - timer0 lower to 5, upper to 6
// - large variant timer1 upper 14, lower 22
// - reduced variant lacks groups 2,3 and sources
// - unimplemented reads return undefined value
module ilvu_top #(
  parameter REDUCED = 0
) (
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire ext_ch2_i,
  input wire ext_ch3_i,
  input wire ext_ch4_i,
  input wire ext_ch5_i,
  input wire ext_ch6_i,
  input wire ext_ch7_i,
  input wire tmr0_lo_i,
  input wire tmr0_hi_i,
  input wire tmr1_lo_i,
  input wire tmr1_hi_i,
  input wire uart_rx_i,
  input wire uart_tx_i,
  input wire adc_i,
  input wire tbt_i,
  input wire wpre_i,
  input wire flash_i,
  input wire [1:0] cpu_lvl_i,
  output reg irq_req_o,
  output reg [4:0] irq_num_o,
  output reg [1:0] irq_lvl_o,
  output reg [15:0] vec_hi_addr_o,
  output reg [15:0] vec_lo_addr_o,
  output reg int_o
);
  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  reg [7:0] lvl_grp [0:5];
  reg [23:0] pend_stat;
  reg [23:0] pend_mask;
  reg [7:0] ctrl;
  wire [23:0] req_raw;
  wire [23:0] req_edge;
  reg [23:0] req_prev;
  wire [47:0] lvl_flat;
  integer k;

  // reduced variant has no groups 2 and 3
  function grp_ok;
    input [2:0] g;
    begin
      grp_ok = (REDUCED == 0) || (g != 3'd2 && g != 3'd3);
    end
  endfunction

  // level groups: four two-bit fields, first group holds requests 0..3
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (k = 0; k < 6; k = k + 1) begin
        lvl_grp[k] <= `ILVU_LVL_RST;
      end
    end else if (wr_i) begin
      // writes to absent locations are simply dropped
      if (addr_i == `ILVU_OFF_LVL0) begin
        lvl_grp[0] <= wdata_i;
      end else if (addr_i == `ILVU_OFF_LVL1) begin
        lvl_grp[1] <= wdata_i;
      end else if (addr_i == `ILVU_OFF_LVL2 && grp_ok(3'd2)) begin
        lvl_grp[2] <= wdata_i;
      end else if (addr_i == `ILVU_OFF_LVL3 && grp_ok(3'd3)) begin
        lvl_grp[3] <= wdata_i;
      end else if (addr_i == `ILVU_OFF_LVL4) begin
        lvl_grp[4] <= wdata_i;
      end else if (addr_i == `ILVU_OFF_LVL5) begin
        lvl_grp[5] <= wdata_i;
      end
    end
  end

  // flatten groups into one field per request
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : gen_flat
      assign lvl_flat[g*8 +: 8] = lvl_grp[g];
    end
  endgenerate

  // ------------------------------------------------------------
  // request mapping
  // ------------------------------------------------------------
  // all sources come from logic on this clock, so no synchroniser
  wire big = (REDUCED == 0);
  assign req_raw[0] = ext_ch4_i;
  assign req_raw[1] = big & ext_ch5_i;
  assign req_raw[2] = (big & ext_ch2_i) | ext_ch6_i;
  assign req_raw[3] = big & (ext_ch3_i | ext_ch7_i);
  assign req_raw[4] = 1'b0;
  assign req_raw[5] = tmr0_lo_i;
  assign req_raw[6] = tmr0_hi_i;
  assign req_raw[7] = big & uart_rx_i;
  assign req_raw[8] = big & uart_tx_i;
  assign req_raw[13:9] = 5'h00;
  assign req_raw[14] = big & tmr1_hi_i;
  assign req_raw[17:15] = 3'h0;
  assign req_raw[18] = adc_i;
  assign req_raw[19] = tbt_i;
  assign req_raw[20] = wpre_i;
  assign req_raw[21] = 1'b0;
  assign req_raw[22] = big & tmr1_lo_i;
  assign req_raw[23] = flash_i;

  // ------------------------------------------------------------
  // priority resolution
  // ------------------------------------------------------------
  // a request is a candidate when its level beats the cpu level;
  // level 3 can never beat anything, so reset masks everything
  wire [23:0] cand;
  wire [31:0] t_vld;
  wire [63:0] t_lvl;
  wire [159:0] t_num;
  genvar i;
  generate
    for (i = 0; i < 24; i = i + 1) begin : gen_cand
      assign cand[i] = req_raw[i] &&
        (lvl_flat[2*i +: 2] < cpu_lvl_i);
    end
    // tree of 32 leaves, leaves 24..31 empty
    for (i = 0; i < 32; i = i + 1) begin : gen_leaf
      // leaf number as a sized constant, a loop index has no bit range
      localparam [4:0] leaf_num = i;
      if (i < 24) begin : g_used
        assign t_vld[i] = cand[i];
        assign t_lvl[2*i +: 2] = lvl_flat[2*i +: 2];
      end else begin : g_empty
        assign t_vld[i] = 1'b0;
        assign t_lvl[2*i +: 2] = `ILVU_LVL_LOW;
      end
      assign t_num[5*i +: 5] = leaf_num;
    end
  endgenerate

  // internal nodes 1..31 heap order, node n has children 2n, 2n+1
  wire [31:0] n_vld;
  wire [63:0] n_lvl;
  wire [159:0] n_num;
  assign n_vld[0] = 1'b0;
  assign n_lvl[1:0] = `ILVU_LVL_LOW;
  assign n_num[4:0] = 5'h00;
  genvar n;
  generate
    for (n = 1; n < 32; n = n + 1) begin : gen_node
      wire av, bv;
      wire [1:0] al, bl;
      wire [4:0] an, bn;
      if (n >= 16) begin : g_bot
        assign av = t_vld[2*(n-16)];
        assign al = t_lvl[4*(n-16) +: 2];
        assign an = t_num[10*(n-16) +: 5];
        assign bv = t_vld[2*(n-16)+1];
        assign bl = t_lvl[4*(n-16)+2 +: 2];
        assign bn = t_num[10*(n-16)+5 +: 5];
      end else begin : g_mid
        assign av = n_vld[2*n];
        assign al = n_lvl[4*n +: 2];
        assign an = n_num[10*n +: 5];
        assign bv = n_vld[2*n+1];
        assign bl = n_lvl[4*n+2 +: 2];
        assign bn = n_num[10*n+5 +: 5];
      end
      // left child always carries the lower numbers
      ilvu_prio_cell u_cell (
        .a_vld_i(av),
        .a_lvl_i(al),
        .a_num_i(an),
        .b_vld_i(bv),
        .b_lvl_i(bl),
        .b_num_i(bn),
        .o_vld_o(n_vld[n]),
        .o_lvl_o(n_lvl[2*n +: 2]),
        .o_num_o(n_num[5*n +: 5])
      );
    end
  endgenerate

  wire win_vld = n_vld[1];
  wire [1:0] win_lvl = n_lvl[3:2];
  wire [4:0] win_num = n_num[9:5];
  wire [15:0] win_vec;
  // two bytes per request going down from the top pair
  assign win_vec = `ILVU_VEC_TOP - {10'h000, win_num, 1'b0};

  // registered vector presentation to the core
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_req_o <= 1'b0;
      irq_num_o <= 5'h00;
      irq_lvl_o <= `ILVU_LVL_LOW;
      vec_hi_addr_o <= `ILVU_VEC_TOP;
      vec_lo_addr_o <= `ILVU_VEC_TOP + 16'h0001;
    end else begin
      irq_req_o <= win_vld;
      irq_num_o <= win_num;
      irq_lvl_o <= win_lvl;
      vec_hi_addr_o <= win_vec;
      vec_lo_addr_o <= win_vec + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // event status, mask and interrupt output
  // ------------------------------------------------------------
  // rising edge of each request sets a sticky bit; set beats clear
  assign req_edge = req_raw & ~req_prev;
  reg [23:0] clr_vec;
  always @* begin
    clr_vec = `ILVU_ZERO24;
    if (wr_i) begin
      if (addr_i == `ILVU_OFF_STAT0) begin
        clr_vec[7:0] = wdata_i;
      end else if (addr_i == `ILVU_OFF_STAT1) begin
        clr_vec[15:8] = wdata_i;
      end else if (addr_i == `ILVU_OFF_STAT2) begin
        clr_vec[23:16] = wdata_i;
      end
    end
  end

  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_prev <= `ILVU_ZERO24;
      pend_stat <= `ILVU_ZERO24;
      pend_mask <= `ILVU_ZERO24;
      ctrl <= `ILVU_CTRL_RST;
      int_o <= 1'b0;
    end else begin
      req_prev <= req_raw;
      pend_stat <= (pend_stat & ~clr_vec) | req_edge;
      if (wr_i && addr_i == `ILVU_OFF_MASK0) begin
        pend_mask[7:0] <= wdata_i;
      end else if (wr_i && addr_i == `ILVU_OFF_MASK1) begin
        pend_mask[15:8] <= wdata_i;
      end else if (wr_i && addr_i == `ILVU_OFF_MASK2) begin
        pend_mask[23:16] <= wdata_i;
      end
      if (wr_i && addr_i == `ILVU_OFF_CTRL) begin
        ctrl <= wdata_i;
      end
      // same edge as the status flop, from its updated value
      int_o <= |(((pend_stat & ~clr_vec) | req_edge) & pend_mask);
    end
  end

  // ------------------------------------------------------------
  // read port: data one cycle after the strobe
  // ------------------------------------------------------------
  reg [7:0] next_rdata;
  always @* begin
    next_rdata = `ILVU_UNDEF;
    if (addr_i == `ILVU_OFF_LVL0) begin
      next_rdata = lvl_grp[0];
    end else if (addr_i == `ILVU_OFF_LVL1) begin
      next_rdata = lvl_grp[1];
    end else if (addr_i == `ILVU_OFF_LVL2 && grp_ok(3'd2)) begin
      next_rdata = lvl_grp[2];
    end else if (addr_i == `ILVU_OFF_LVL3 && grp_ok(3'd3)) begin
      next_rdata = lvl_grp[3];
    end else if (addr_i == `ILVU_OFF_LVL4) begin
      next_rdata = lvl_grp[4];
    end else if (addr_i == `ILVU_OFF_LVL5) begin
      next_rdata = lvl_grp[5];
    end else if (addr_i == `ILVU_OFF_STAT0) begin
      next_rdata = pend_stat[7:0];
    end else if (addr_i == `ILVU_OFF_STAT1) begin
      next_rdata = pend_stat[15:8];
    end else if (addr_i == `ILVU_OFF_STAT2) begin
      next_rdata = pend_stat[23:16];
    end else if (addr_i == `ILVU_OFF_MASK0) begin
      next_rdata = pend_mask[7:0];
    end else if (addr_i == `ILVU_OFF_MASK1) begin
      next_rdata = pend_mask[15:8];
    end else if (addr_i == `ILVU_OFF_MASK2) begin
      next_rdata = pend_mask[23:16];
    end else if (addr_i == `ILVU_OFF_CTRL) begin
      next_rdata = ctrl;
    end
  end

  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= `ILVU_ZERO8;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end
  end
endmodule // ilvu_top

// >>> verif/ilvu_cpu_model.sv
`timescale 1ns/1ns
// ----
// cpu core side: level register and vector fetch
// ----
module ilvu_cpu_model (
  input wire ref_clk_i,
  input wire irq_req_i,
  input wire [15:0] vec_i,
  input wire [1:0] lvl_set_i,
  output logic [1:0] cpu_lvl_o,
  output logic [15:0] fetch_o
);
  // level changes one edge late, like a flag written by software
  always @(posedge ref_clk_i) begin
    cpu_lvl_o <= lvl_set_i;
    if (irq_req_i) begin
      fetch_o <= vec_i;
    end
  end
endmodule // ilvu_cpu_model

// >>> verif/ilvu_monitor.sv
`timescale 1ns/1ns
// ----
// checker on the top ports
// ----
module ilvu_monitor (
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire [1:0] cpu_lvl_i,
  input wire irq_req_o,
  input wire [4:0] irq_num_o,
  input wire [1:0] irq_lvl_o,
  input wire [15:0] vec_hi_addr_o,
  input wire [15:0] vec_lo_addr_o,
  input wire int_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // vector address pair and its place in the table
  vec_pair_a: assert property (vec_lo_addr_o == vec_hi_addr_o + 16'h0001)
    else $error("vector pair not adjacent");
  vec_map_a: assert property (
    vec_hi_addr_o == 16'hfffa - {10'h000, irq_num_o, 1'b0})
    else $error("vector does not match request number");
  num_range_a: assert property (irq_req_o |-> irq_num_o <= 5'h17)
    else $error("request number out of range");
  // level 3 never reaches the cpu, others only above its level
  low_masked_a: assert property (irq_req_o |-> irq_lvl_o != 2'h3)
    else $error("lowest level forwarded");
  fwd_lvl_a: assert property (irq_req_o |-> irq_lvl_o < $past(cpu_lvl_i))
    else $error("request not more urgent than cpu");
  // level group write then read back, as the bench spaces it
  wr_rd_a: assert property ((wr_i && addr_i == 8'h79) ##2
    (rd_i && addr_i == 8'h79) |=> rdata_o == $past(wdata_i, 3))
    else $error("level group read back differs");
  rd_hold_a: assert property (!rd_i |=> $stable(rdata_o))
    else $error("read data moved without a read");
  rst_rel_a: assert property ($rose(rst_b_i) |->
    !irq_req_o && irq_lvl_o == 2'h3 && !int_o)
    else $error("outputs not at reset state");
endmodule // ilvu_monitor

// >>> verif/tb.sv
`timescale 1ns/1ns
// ----
// testbench top
// ----
module tb;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [15:0] src = 16'h0000;
  logic [1:0] lvl_set = 2'h3;
  logic [7:0] rv;
  logic [7:0] rv_r;
  logic [7:0] grp [6] = '{8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h7d, 8'h7e};
  // sources that still reach a request line in the reduced variant
  logic [15:0] rmask = 16'hf0d4;
  int exp_num [16] = '{2, 3, 0, 1, 2, 3, 5, 6, 22, 14, 7, 8, 18, 19, 20, 23};
  int miscompares = 0;
  int n_compared = 0;
  int i;
  wire [1:0] cpu_lvl_i;
  wire [7:0] rdata_o, rdata_r;
  wire irq_req_o, int_o, irq_req_r;
  wire [4:0] irq_num_o;
  wire [1:0] irq_lvl_o;
  wire [15:0] vec_hi_addr_o, vec_lo_addr_o, fetch;
  // one bit of src per request source, in port order
  wire ext_ch2_i = src[0], ext_ch3_i = src[1], ext_ch4_i = src[2];
  wire ext_ch5_i = src[3], ext_ch6_i = src[4], ext_ch7_i = src[5];
  wire tmr0_lo_i = src[6], tmr0_hi_i = src[7], tmr1_lo_i = src[8];
  wire tmr1_hi_i = src[9], uart_rx_i = src[10], uart_tx_i = src[11];
  wire adc_i = src[12], tbt_i = src[13], wpre_i = src[14], flash_i = src[15];

  always #5 ref_clk_i = ~ref_clk_i;
  ilvu_top #(.REDUCED(0)) DUT (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .ext_ch2_i(ext_ch2_i), .ext_ch3_i(ext_ch3_i),
    .ext_ch4_i(ext_ch4_i), .ext_ch5_i(ext_ch5_i), .ext_ch6_i(ext_ch6_i),
    .ext_ch7_i(ext_ch7_i), .tmr0_lo_i(tmr0_lo_i), .tmr0_hi_i(tmr0_hi_i),
    .tmr1_lo_i(tmr1_lo_i), .tmr1_hi_i(tmr1_hi_i), .uart_rx_i(uart_rx_i),
    .uart_tx_i(uart_tx_i), .adc_i(adc_i), .tbt_i(tbt_i), .wpre_i(wpre_i),
    .flash_i(flash_i), .cpu_lvl_i(cpu_lvl_i), .irq_req_o(irq_req_o),
    .irq_num_o(irq_num_o), .irq_lvl_o(irq_lvl_o),
    .vec_hi_addr_o(vec_hi_addr_o), .vec_lo_addr_o(vec_lo_addr_o),
    .int_o(int_o));
  ilvu_cpu_model cpu (.ref_clk_i(ref_clk_i), .irq_req_i(irq_req_o),
    .vec_i(vec_hi_addr_o), .lvl_set_i(lvl_set), .cpu_lvl_o(cpu_lvl_i),
    .fetch_o(fetch));
  // reduced variant on the same pins; its software leaves the absent
  // level groups alone, so those writes are kept off its strobe
  wire wr_r = wr_i && addr_i != 8'h7b && addr_i != 8'h7c;
  ilvu_top #(.REDUCED(1)) DUT_R (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_r), .rd_i(rd_i),
    .rdata_o(rdata_r), .ext_ch2_i(ext_ch2_i), .ext_ch3_i(ext_ch3_i),
    .ext_ch4_i(ext_ch4_i), .ext_ch5_i(ext_ch5_i), .ext_ch6_i(ext_ch6_i),
    .ext_ch7_i(ext_ch7_i), .tmr0_lo_i(tmr0_lo_i), .tmr0_hi_i(tmr0_hi_i),
    .tmr1_lo_i(tmr1_lo_i), .tmr1_hi_i(tmr1_hi_i), .uart_rx_i(uart_rx_i),
    .uart_tx_i(uart_tx_i), .adc_i(adc_i), .tbt_i(tbt_i), .wpre_i(wpre_i),
    .flash_i(flash_i), .cpu_lvl_i(cpu_lvl_i), .irq_req_o(irq_req_r),
    .irq_num_o(), .irq_lvl_o(), .vec_hi_addr_o(), .vec_lo_addr_o(),
    .int_o());

  task chk(input string what, input logic [15:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // only mapped offsets are ever written from here
  task wr(input logic [7:0] a, d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
    rv_r = rdata_r;
  endtask
  // request path answers in one cycle, the cpu level one more
  task settle;
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask
  task drive(input logic [15:0] s);
    @(posedge ref_clk_i);
    src <= s;
    settle;
  endtask
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // a hang is cut short and counted
  initial begin
    #200000;
    miscompares++;
    final_report;
  end

  initial begin
    repeat (2) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    for (i = 0; i < 6; i++) begin
      rd(grp[i]);
      chk("level reset", 16'h00ff, {8'h00, rv});
      wr(grp[i], 8'h00);
      rd(grp[i]);
      chk("level rw", 16'h0000, {8'h00, rv});
    end
    rd(8'h70);
    chk("unmapped read", 16'h00a5, {8'h00, rv});
    rd(8'h7b);
    chk("reduced gap", 16'h00a5, {8'h00, rv_r});
    rd(8'h68);
    chk("ctrl reset", 16'h0003, {8'h00, rv});
    // every source alone at level 0 under cpu level 3
    for (i = 0; i < 16; i++) begin
      drive(16'h0001 << i);
      chk("number", exp_num[i], {11'h000, irq_num_o});
      chk("fetch", 16'hfffa - 2 * exp_num[i], fetch);
      chk("vector lo", 16'hfffb - 2 * exp_num[i], vec_lo_addr_o);
      chk("reduced req", {15'h0000, rmask[i]}, {15'h0000, irq_req_r});
    end
    drive(16'hffff);
    chk("all pending", 16'h0000, {11'h000, irq_num_o});
    drive(16'h3000);
    chk("tie", 16'h0012, {11'h000, irq_num_o});
    wr(8'h7d, 8'h1f);
    settle;
    chk("level wins", 16'h0013, {11'h000, irq_num_o});
    chk("win level", 16'h0000, {14'h0000, irq_lvl_o});
    lvl_set <= 2'h0;
    settle;
    chk("cpu blocks", 16'h0000, {15'h0000, irq_req_o});
    lvl_set <= 2'h1;
    settle;
    chk("cpu passes", 16'h0001, {15'h0000, irq_req_o});
    wr(8'h7d, 8'hff);
    settle;
    chk("level 3 held", 16'h0000, {15'h0000, irq_req_o});
    // status, mask and the level interrupt
    // earlier scenarios left many status bits set; clear them all first
    drive(16'h0000);
    wr(8'h60, 8'hff);
    wr(8'h61, 8'hff);
    wr(8'h62, 8'hff);
    drive(16'h0004);
    chk("masked int", 16'h0000, {15'h0000, int_o});
    rd(8'h62);
    chk("status hi", 16'h0000, {8'h00, rv});
    rd(8'h60);
    chk("status", 16'h0001, {8'h00, rv});
    wr(8'h64, 8'h01);
    settle;
    chk("int set", 16'h0001, {15'h0000, int_o});
    drive(16'h0000);
    wr(8'h60, 8'h01);
    settle;
    chk("int clear", 16'h0000, {15'h0000, int_o});
    final_report;
  end
endmodule // tb

bind ilvu_top ilvu_monitor mon (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .cpu_lvl_i(cpu_lvl_i), .irq_req_o(irq_req_o),
  .irq_num_o(irq_num_o), .irq_lvl_o(irq_lvl_o),
  .vec_hi_addr_o(vec_hi_addr_o), .vec_lo_addr_o(vec_lo_addr_o),
  .int_o(int_o));
